// ==== pei_pkg.sv ====
// shared constants and carriers for the power-event interrupt block
// assumes a single 125 MHz system clock; all slow times are counted in 1 ms ticks
package pei_pkg;

  // clock rate and the derived tick rates
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

  // times in milliseconds or seconds, as printed
  localparam int unsigned DEB_SHORT_MS = 1;
  localparam int unsigned DEB_LONG_S = 1;
  localparam int unsigned START_MS = 500;
  localparam int unsigned PREFR_MS = 66;
  localparam int unsigned DELAY1_MS = 3;
  localparam int unsigned DELAY2_MS = 1;

  // counts of 1 ms ticks derived from the times (the refresh lies inside the start-up)
  localparam int unsigned DEB_LONG_MS = DEB_LONG_S * MS_PER_S;
  localparam int unsigned MS_W = 10;

  // switchover mode field encodings
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;

  // reset values of the working state
  localparam logic RST_SWITCHOVER_FLAG = 1'h0;
  localparam logic RST_POWER_LOSS_FLAG = 1'h1;
  localparam logic RST_UNDERVOLTAGE_FLAG = 1'h0;
  localparam logic RST_IRQ_ENABLE = 1'h0;

  // host accesses, one cycle each, as decoded by the serial bus front end
  typedef struct packed {
    logic clr_switchover;
    logic clr_power_loss;
    logic clr_undervoltage;
    logic set_enables;
    logic switchover_ie;
    logic power_loss_ie;
    logic undervoltage_ie;
  } pei_host_req_t;

  // the three event flags
  typedef struct packed {
    logic switchover;
    logic power_loss;
    logic undervoltage;
  } pei_flags_t;

  // supply state machine
  typedef enum logic [1:0] {
    SUP_MAIN = 2'b00,
    SUP_BACKUP = 2'b01,
    SUP_DEBOUNCE = 2'b10
  } pei_supply_t;

endpackage : pei_pkg

// ==== pei_sync.sv ====
// two-flop synchroniser for a group of asynchronous levels
// assumes inputs are quasi-static levels; the first stage feeds only the second
`timescale 1ns/1ps
module pei_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // plain double registering, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : pei_sync

// ==== pei_tick_div.sv ====
// divider giving one-cycle 1 ms and 1 s enable pulses from the system clock
// assumes one clock; the pulses are registered and never coincide with reset
`timescale 1ns/1ps
module pei_tick_div #(
  parameter int unsigned CYC_PER_MS = pei_pkg::CYC_PER_MS,
  parameter int unsigned MS_PER_S = pei_pkg::MS_PER_S
) (
  input wire logic clk_sys,
  input wire logic resetn,
  output logic ms_tick,
  output logic s_tick
);

  localparam int unsigned CW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
  localparam int unsigned MW = (MS_PER_S > 1) ? $clog2(MS_PER_S) : 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);
  localparam logic [MW-1:0] MS_LAST = MW'(MS_PER_S - 1);

  logic [CW-1:0] cyc_q;
  logic [MW-1:0] ms_q;

  // cycle prescaler, wraps once per millisecond
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cyc_q <= '0;
      ms_tick <= 1'h0;
    end else begin
      ms_tick <= (cyc_q == CYC_LAST);
      cyc_q <= (cyc_q == CYC_LAST) ? '0 : cyc_q + 1'b1;
    end
  end

  // millisecond counter, wraps once per second
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ms_q <= '0;
      s_tick <= 1'h0;
    end else begin
      s_tick <= 1'h0;
      if (cyc_q == CYC_LAST) begin
        s_tick <= (ms_q == MS_LAST);
        ms_q <= (ms_q == MS_LAST) ? '0 : ms_q + 1'b1;
      end
    end
  end

endmodule : pei_tick_div

// ==== pei_power_events.sv ====
// power-event flags and alert line: backup switchover, power-loss reset, undervoltage
// assumes supply comparators arrive as asynchronous levels; host strobes are on clk_sys
//
// Function
// - switchover counts only when mode field selects direct or level mode
// - enabled switchover with flag clear sets flag and pulls alert low
// - return to main supply debounced 1 ms, or 1 s after undervoltage
// - bus accesses refused until debounce after return to main completes
// - power-loss enable loaded from nonvolatile copy after 0.5 s start-up
// - power-on reset sets power-loss flag, held until host writes zero
// - power-loss alert goes low about 1 ms after reset when enabled
// - clock output driven high 3 ms after reset when not disabled
// - power-loss alert follows its enable; clearing flag releases alert
// - internal supply sampled once per second against low threshold
// - within one second of drop set undervoltage flag, alert if enabled
// - while low: compensation stopped, clock output low, bus disabled
// - within one second of recovery resume; undervoltage flag stays set
// - undervoltage flag cleared at power-on reset, otherwise only by host
// - undervoltage alert follows its enable while flag set
// - undervoltage enable loaded from nonvolatile copy after 0.5 s start-up
`timescale 1ns/1ps
module pei_power_events #(
  parameter int unsigned CYC_PER_MS = pei_pkg::CYC_PER_MS,
  parameter int unsigned MS_PER_S = pei_pkg::MS_PER_S
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic backup_supply_state,
  input wire logic main_below_por,
  input wire logic internal_below_low,
  input wire logic alert_n_i,
  input wire logic [1:0] switchover_mode_field,
  input wire logic nv_power_loss_irq_enable,
  input wire logic nv_undervoltage_irq_enable,
  input wire logic clock_output_disable,
  input wire pei_pkg::pei_host_req_t host_req,
  output pei_pkg::pei_flags_t flags,
  output logic switchover_irq_enable,
  output logic power_loss_irq_enable,
  output logic undervoltage_irq_enable,
  output logic alert_n_o,
  output logic alert_n_oe,
  output logic alert_n_level,
  output logic clock_output_pin,
  output logic comp_enable,
  output logic bus_enable
);

  localparam int unsigned MS_W = pei_pkg::MS_W;
  localparam logic [MS_W-1:0] START_CNT = MS_W'(pei_pkg::START_MS);
  localparam logic [MS_W-1:0] DELAY1_CNT = MS_W'(pei_pkg::DELAY1_MS);
  localparam logic [MS_W-1:0] DELAY2_CNT = MS_W'(pei_pkg::DELAY2_MS);
  localparam logic [MS_W-1:0] DEB_SHORT_CNT = MS_W'(pei_pkg::DEB_SHORT_MS);
  localparam logic [MS_W-1:0] DEB_LONG_CNT = MS_W'(pei_pkg::DEB_LONG_MS);

  logic ms_tick;
  logic s_tick;
  logic [3:0] pins_s;
  logic backup_s;
  logic por_s;
  logic low_s;
  pei_pkg::pei_supply_t state_q;
  pei_pkg::pei_supply_t state_d;
  logic [MS_W-1:0] deb_cnt_q;
  logic [MS_W-1:0] deb_len;
  logic [MS_W-1:0] por_cnt_q;
  logic uv_low_q;
  logic uv_seen_q;
  logic mode_ok;
  logic sw_event;
  logic nv_load;
  logic host_ok;
  logic alert_d;

  pei_tick_div #(
    .CYC_PER_MS(CYC_PER_MS),
    .MS_PER_S(MS_PER_S)
  ) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ms_tick(ms_tick),
    .s_tick(s_tick)
  );

  // every pin level crosses two flops before any logic looks at it
  pei_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d({alert_n_i, internal_below_low, main_below_por, backup_supply_state}),
    .q(pins_s)
  );

  assign backup_s = pins_s[0];
  assign por_s = pins_s[1];
  assign low_s = pins_s[2];

  // host accesses land only while the serial interface is enabled
  assign host_ok = bus_enable;
  assign mode_ok = (switchover_mode_field == pei_pkg::MODE_DIRECT)
                 || (switchover_mode_field == pei_pkg::MODE_LEVEL);
  assign sw_event = (state_q == pei_pkg::SUP_MAIN) && backup_s && mode_ok;
  // a dip into undervoltage while on backup stretches the debounce to one second
  assign deb_len = uv_seen_q ? DEB_LONG_CNT : DEB_SHORT_CNT;

  // start-up sequencer: counts milliseconds from the release of a power-on reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      por_cnt_q <= '0;
    end else if (por_s) begin
      por_cnt_q <= '0;
    end else if (ms_tick && (por_cnt_q != START_CNT)) begin
      por_cnt_q <= por_cnt_q + 1'b1;
    end
  end

  // one-cycle pulse at the end of the start-up time copies the nonvolatile enables
  assign nv_load = ms_tick && !por_s && (por_cnt_q == START_CNT - 1'b1);

  // supply state machine: main, backup, debounce of the way back
  always_comb begin
    state_d = state_q;
    case (state_q)
      pei_pkg::SUP_MAIN: begin
        if (backup_s) begin
          state_d = pei_pkg::SUP_BACKUP;
        end
      end
      pei_pkg::SUP_BACKUP: begin
        if (!backup_s) begin
          state_d = pei_pkg::SUP_DEBOUNCE;
        end
      end
      pei_pkg::SUP_DEBOUNCE: begin
        if (backup_s) begin
          state_d = pei_pkg::SUP_BACKUP; // main supply bounced, start over
        end else if (ms_tick && (deb_cnt_q + 1'b1 >= deb_len)) begin
          state_d = pei_pkg::SUP_MAIN;
        end
      end
      default: begin
        state_d = pei_pkg::SUP_MAIN;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= pei_pkg::SUP_MAIN;
    end else begin
      state_q <= state_d;
    end
  end

  // debounce counter runs only inside the debounce state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      deb_cnt_q <= '0;
    end else if (state_q != pei_pkg::SUP_DEBOUNCE) begin
      deb_cnt_q <= '0;
    end else if (ms_tick) begin
      deb_cnt_q <= deb_cnt_q + 1'b1;
    end
  end

  // remember an undervoltage seen away from the main supply until back on main
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      uv_seen_q <= 1'h0;
    end else if (state_q == pei_pkg::SUP_MAIN) begin
      uv_seen_q <= 1'h0;
    end else if (uv_low_q) begin
      uv_seen_q <= 1'h1;
    end
  end

  // internal supply sampled once a second in every supply state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      uv_low_q <= 1'h0;
    end else if (s_tick) begin
      uv_low_q <= low_s;
    end
  end

  // switchover flag: set only when enabled and clear before; set beats clear
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags.switchover <= pei_pkg::RST_SWITCHOVER_FLAG;
    end else if (sw_event && switchover_irq_enable && !flags.switchover) begin
      flags.switchover <= 1'h1;
    end else if (host_ok && host_req.clr_switchover) begin
      flags.switchover <= 1'h0;
    end
  end

  // power-loss flag: raised by every power-on reset, only the host drops it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags.power_loss <= pei_pkg::RST_POWER_LOSS_FLAG;
    end else if (por_s) begin
      flags.power_loss <= 1'h1;
    end else if (host_ok && host_req.clr_power_loss) begin
      flags.power_loss <= 1'h0;
    end
  end

  // undervoltage flag: cleared by power-on reset, set by a low sample, else host only
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags.undervoltage <= pei_pkg::RST_UNDERVOLTAGE_FLAG;
    end else if (por_s) begin
      flags.undervoltage <= 1'h0;
    end else if (s_tick && low_s) begin
      flags.undervoltage <= 1'h1;
    end else if (host_ok && host_req.clr_undervoltage) begin
      flags.undervoltage <= 1'h0;
    end
  end

  // switchover enable lives only in the working register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      switchover_irq_enable <= pei_pkg::RST_IRQ_ENABLE;
    end else if (host_ok && host_req.set_enables) begin
      switchover_irq_enable <= host_req.switchover_ie;
    end
  end

  // the nonvolatile copy wins over a host write landing in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      power_loss_irq_enable <= pei_pkg::RST_IRQ_ENABLE;
      undervoltage_irq_enable <= pei_pkg::RST_IRQ_ENABLE;
    end else if (nv_load) begin
      power_loss_irq_enable <= nv_power_loss_irq_enable;
      undervoltage_irq_enable <= nv_undervoltage_irq_enable;
    end else if (host_ok && host_req.set_enables) begin
      power_loss_irq_enable <= host_req.power_loss_ie;
      undervoltage_irq_enable <= host_req.undervoltage_ie;
    end
  end

  // alert term: any flag with its enable; power loss waits out the short delay
  assign alert_d = (flags.switchover && switchover_irq_enable)
                 || (flags.power_loss && power_loss_irq_enable
                     && (por_cnt_q >= DELAY2_CNT) && !por_s)
                 || (flags.undervoltage && undervoltage_irq_enable);

  // open-drain alert: only ever pulls low, enable is the assertion itself
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      alert_n_o <= 1'h0;
      alert_n_oe <= 1'h0;
      alert_n_level <= 1'h0;
    end else begin
      alert_n_o <= 1'h0;
      alert_n_oe <= alert_d;
      alert_n_level <= pins_s[3];
    end
  end

  // outputs gated by the supply: clock output, compensation, serial interface
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      clock_output_pin <= 1'h0;
      comp_enable <= 1'h0;
      bus_enable <= 1'h0;
    end else begin
      clock_output_pin <= (por_cnt_q >= DELAY1_CNT) && !por_s
                          && !clock_output_disable && !uv_low_q;
      comp_enable <= !uv_low_q;
      bus_enable <= (state_q == pei_pkg::SUP_MAIN) && !backup_s
                    && !uv_low_q && !por_s;
    end
  end

  // checks, all on the one clock with reset as the disable
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_sw_mode_gate: assert property ($rose(flags.switchover) |-> $past(mode_ok))
    else $error("switchover flag set outside direct or level mode");

  a_sw_flag_set: assert property ((sw_event && switchover_irq_enable && !flags.switchover)
    |=> flags.switchover ##1 alert_n_oe)
    else $error("enabled switchover did not set flag and alert");

  a_deb_end: assert property ((state_q == pei_pkg::SUP_DEBOUNCE) && !backup_s && ms_tick
    && (deb_cnt_q + 1'b1 >= deb_len) |=> (state_q == pei_pkg::SUP_MAIN))
    else $error("debounce did not end at its length");

  a_deb_long: assert property ($rose(state_q == pei_pkg::SUP_MAIN)
    && $past(uv_seen_q) |-> $past(deb_cnt_q) >= DEB_LONG_CNT - 1'b1)
    else $error("long debounce cut short after undervoltage");

  a_bus_after_deb: assert property ($rose(bus_enable)
    |-> $past(state_q) == pei_pkg::SUP_MAIN)
    else $error("bus enabled before debounce completed");

  a_nv_load: assert property (nv_load
    |=> (power_loss_irq_enable == $past(nv_power_loss_irq_enable))
    && (undervoltage_irq_enable == $past(nv_undervoltage_irq_enable)))
    else $error("nonvolatile enables not loaded after start-up");

  a_pl_hold: assert property (flags.power_loss && !(host_ok && host_req.clr_power_loss)
    |=> flags.power_loss)
    else $error("power-loss flag dropped without a host clear");

  // an alert raised by power loss alone must have waited out the short delay
  a_pl_alert_delay: assert property ($rose(alert_n_oe)
    && !$past(flags.switchover && switchover_irq_enable)
    && !$past(flags.undervoltage && undervoltage_irq_enable)
    |-> $past(por_cnt_q) >= DELAY2_CNT)
    else $error("power-loss alert raised with no delay");

  a_clk_delay: assert property (clock_output_pin |-> $past(por_cnt_q) >= DELAY1_CNT)
    else $error("clock output before power-on delay");

  a_uv_stop: assert property (uv_low_q |=> !bus_enable && !clock_output_pin
    && !comp_enable)
    else $error("undervoltage did not stop bus, clock output, compensation");

  a_uv_por_clear: assert property (por_s |=> !flags.undervoltage)
    else $error("undervoltage flag survived power-on reset");

  a_uv_alert: assert property (flags.undervoltage && undervoltage_irq_enable
    |=> alert_n_oe)
    else $error("undervoltage alert not asserted");

  a_alert_release: assert property (!flags.switchover && !flags.power_loss
    && !flags.undervoltage |=> !alert_n_oe)
    else $error("alert held with every flag clear");

  c_switchover: cover property ($rose(flags.switchover));
  c_uv_set: cover property ($rose(flags.undervoltage) ##1 alert_n_oe);
  c_nv_load: cover property (nv_load ##1 power_loss_irq_enable);
  c_deb_long: cover property (uv_seen_q && (state_q == pei_pkg::SUP_DEBOUNCE));

endmodule : pei_power_events

// ==== pei_host_model.sv ====
// host controller model: turns flag clears and enable writes into one-cycle host strobes
// assumes the block's bus_enable gate; strobes change only just after rising clk_sys
`timescale 1ns/1ps
module pei_host_model (
  input wire logic clk_sys,
  input wire logic bus_enable,
  output pei_pkg::pei_host_req_t host_req
);
  // shadow of the working enables {switchover, power_loss, undervoltage}
  // a real host would read them back; all enable writes here go through set_en
  logic [2:0] en_q;

  // strobes idle at time zero so nothing is taken before reset ends
  initial begin
    host_req = '0;
    en_q = 3'h0;
  end

  // one strobe, held for exactly one sampled edge
  task automatic send(input pei_pkg::pei_host_req_t req, input bit wait_bus);
    @(posedge clk_sys);
    for (int i = 0; i < 6000 && wait_bus && bus_enable !== 1'b1; i++) @(posedge clk_sys);
    host_req <= req;
    @(posedge clk_sys);
    host_req <= '0;
  endtask : send

  // write zero to the chosen flags; wait_bus low models an access while the bus is off
  task automatic clear(input logic sw, input logic pl, input logic uv, input bit wait_bus);
    pei_pkg::pei_host_req_t r;
    r = '0;
    r.clr_switchover = sw;
    r.clr_power_loss = pl;
    r.clr_undervoltage = uv;
    send(r, wait_bus);
  endtask : clear

  // all three working enables are written together
  task automatic set_en(input logic sw, input logic pl, input logic uv);
    pei_pkg::pei_host_req_t r;
    r = '0;
    r.set_enables = 1'b1;
    r.switchover_ie = sw;
    r.power_loss_ie = pl;
    r.undervoltage_ie = uv;
    en_q = {sw, pl, uv};
    send(r, 1'b1);
  endtask : set_en

  // enable off, flag cleared, enable on; the caller writes the mode afterwards
  task automatic arm_switchover(input logic ie);
    set_en(1'b0, en_q[1], en_q[0]);
    clear(1'b1, 1'b0, 1'b0, 1'b1);
    set_en(ie, en_q[1], en_q[0]);
  endtask : arm_switchover

  // same order for the undervoltage pair, avoiding a stray alert
  task automatic arm_undervoltage(input logic ie);
    set_en(en_q[2], en_q[1], 1'b0);
    clear(1'b0, 1'b0, 1'b1, 1'b1);
    set_en(en_q[2], en_q[1], ie);
  endtask : arm_undervoltage
endmodule : pei_host_model

// ==== tb_top.sv ====
// self-checking bench for the power-event block with a host model on the strobe side
// assumes shortened tick parameters: 4 cycles a ms tick, 10 ms ticks a second tick
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned CMS = 4;
  localparam int unsigned MSS = 10;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic backup_supply_state = 1'b0;
  logic main_below_por = 1'b0;
  logic internal_below_low = 1'b0;
  logic alert_n_i;
  logic [1:0] switchover_mode_field = 2'h1;
  logic nv_power_loss_irq_enable = 1'b1;
  logic nv_undervoltage_irq_enable = 1'b1;
  logic clock_output_disable = 1'b0;
  pei_pkg::pei_host_req_t host_req;
  pei_pkg::pei_flags_t flags;
  logic switchover_irq_enable, power_loss_irq_enable, undervoltage_irq_enable;
  logic alert_n_o, alert_n_oe, alert_n_level;
  logic clock_output_pin, comp_enable, bus_enable;
  int err_count = 0;
  int checks = 0;
  logic [1:0] sw_mode [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  logic sw_ie [5] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0};

  // open-drain alert wire with a pull-up: released means high, not the last value
  assign alert_n_i = alert_n_oe ? alert_n_o : 1'b1;

  always #4 clk_sys = ~clk_sys;

  pei_power_events #(.CYC_PER_MS(CMS), .MS_PER_S(MSS)) pei_power_events_i (
    .clk_sys(clk_sys), .resetn(resetn), .backup_supply_state(backup_supply_state),
    .main_below_por(main_below_por), .internal_below_low(internal_below_low),
    .alert_n_i(alert_n_i), .switchover_mode_field(switchover_mode_field),
    .nv_power_loss_irq_enable(nv_power_loss_irq_enable),
    .nv_undervoltage_irq_enable(nv_undervoltage_irq_enable),
    .clock_output_disable(clock_output_disable), .host_req(host_req), .flags(flags),
    .switchover_irq_enable(switchover_irq_enable),
    .power_loss_irq_enable(power_loss_irq_enable),
    .undervoltage_irq_enable(undervoltage_irq_enable), .alert_n_o(alert_n_o),
    .alert_n_oe(alert_n_oe), .alert_n_level(alert_n_level),
    .clock_output_pin(clock_output_pin), .comp_enable(comp_enable), .bus_enable(bus_enable)
  );

  pei_host_model pei_host_model_i (
    .clk_sys(clk_sys), .bus_enable(bus_enable), .host_req(host_req)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_flags(input pei_pkg::pei_flags_t got, input logic [2:0] exp,
                             input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_flags

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // watchdog sized at about twice the planned run of some 11000 cycles
  initial begin
    tick(25000);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  // main sequence: power-on, power-loss alert, switchover modes, undervoltage, resets
  initial begin
    logic exp;
    logic sel;
    tick(6);
    #1;
    check_flags(flags, 3'h2, "reset flags");
    check_bit(alert_n_oe, 1'h0, "reset alert");
    tick(2);
    resetn <= 1'b1;
    tick(4);
    #1;
    check_bit(clock_output_pin, 1'h0, "clock output early");
    tick(20);
    #1;
    check_bit(clock_output_pin, 1'h1, "clock output on");
    tick(1876);
    #1;
    check_bit(power_loss_irq_enable, 1'h0, "power-loss enable early");
    check_bit(alert_n_oe, 1'h0, "alert before load");
    tick(200);
    #1;
    check_bit(power_loss_irq_enable, 1'h1, "power-loss enable loaded");
    check_bit(undervoltage_irq_enable, 1'h1, "undervoltage enable loaded");
    check_bit(alert_n_oe, 1'h1, "power-loss alert");
    check_bit(alert_n_level, 1'h0, "alert wire low");
    check_bit(alert_n_o, 1'h0, "alert only pulls low");
    pei_host_model_i.set_en(1'h0, 1'h0, 1'h0);
    tick(3);
    #1;
    check_bit(alert_n_oe, 1'h0, "alert follows enable off");
    pei_host_model_i.set_en(1'h0, 1'h1, 1'h0);
    tick(3);
    #1;
    check_bit(alert_n_oe, 1'h1, "alert follows enable on");
    pei_host_model_i.clear(1'h1, 1'h1, 1'h0, 1'b1);
    tick(3);
    #1;
    check_flags(flags, 3'h0, "power-loss flag cleared");
    check_bit(alert_n_oe, 1'h0, "alert released");
    // every mode code, plus a valid mode with the enable off
    for (int k = 0; k < 5; k++) begin
      sel = (sw_mode[k] == pei_pkg::MODE_DIRECT) | (sw_mode[k] == pei_pkg::MODE_LEVEL);
      exp = sw_ie[k] & sel;
      pei_host_model_i.arm_switchover(sw_ie[k]);
      switchover_mode_field <= sw_mode[k];
      tick(1);
      backup_supply_state <= 1'b1;
      tick(8);
      #1;
      check_flags(flags, {exp, 2'h0}, "switchover flag");
      check_bit(alert_n_oe, exp, "switchover alert");
      if (sel) check_bit(bus_enable, 1'h0, "bus off on backup");
      check_bit(switchover_irq_enable, sw_ie[k], "switchover enable armed");
      pei_host_model_i.clear(1'h1, 1'h0, 1'h0, 1'b0);
      tick(3);
      #1;
      check_flags(flags, {exp, 2'h0}, "clear refused on backup");
      tick(1);
      backup_supply_state <= 1'b0;
      for (int i = 0; i < 12 && bus_enable !== 1'b1; i++) tick(1);
      #1;
      check_bit(bus_enable, 1'h1, "short debounce");
      pei_host_model_i.clear(1'h1, 1'h0, 1'h0, 1'b1);
      tick(3);
      #1;
      check_flags(flags, 3'h0, "switchover cleared");
    end
    pei_host_model_i.arm_undervoltage(1'h1);
    internal_below_low <= 1'b1;
    for (int i = 0; i < 46 && flags.undervoltage !== 1'b1; i++) tick(1);
    tick(3);
    #1;
    check_flags(flags, 3'h1, "undervoltage flag set");
    check_bit(alert_n_oe, 1'h1, "undervoltage alert");
    check_bit(bus_enable, 1'h0, "bus off when low");
    check_bit(comp_enable, 1'h0, "compensation off when low");
    check_bit(clock_output_pin, 1'h0, "clock output low when low");
    pei_host_model_i.clear(1'h0, 1'h0, 1'h1, 1'b0);
    tick(1);
    internal_below_low <= 1'b0;
    for (int i = 0; i < 46 && bus_enable !== 1'b1; i++) tick(1);
    tick(2);
    #1;
    check_bit(comp_enable, 1'h1, "compensation resumed");
    check_bit(clock_output_pin, 1'h1, "clock output resumed");
    check_flags(flags, 3'h1, "undervoltage flag kept");
    pei_host_model_i.set_en(1'h0, 1'h1, 1'h0);
    tick(3);
    #1;
    check_bit(alert_n_oe, 1'h0, "undervoltage alert masked");
    pei_host_model_i.set_en(1'h0, 1'h1, 1'h1);
    tick(3);
    #1;
    check_bit(alert_n_oe, 1'h1, "undervoltage alert unmasked");
    pei_host_model_i.clear(1'h0, 1'h0, 1'h1, 1'b1);
    tick(3);
    #1;
    check_flags(flags, 3'h0, "undervoltage flag cleared");
    check_bit(alert_n_oe, 1'h0, "undervoltage alert released");
    // undervoltage seen while on backup stretches the return debounce to a second
    tick(1);
    backup_supply_state <= 1'b1;
    internal_below_low <= 1'b1;
    tick(90);
    #1;
    check_flags(flags, 3'h1, "low sampled on backup");
    tick(1);
    internal_below_low <= 1'b0;
    tick(89);
    backup_supply_state <= 1'b0;
    tick(200);
    #1;
    check_bit(bus_enable, 1'h0, "long debounce holds");
    for (int i = 0; i < 4100 && bus_enable !== 1'b1; i++) tick(1);
    #1;
    check_bit(bus_enable, 1'h1, "long debounce ends");
    tick(1);
    main_below_por <= 1'b1;
    tick(6);
    #1;
    check_flags(flags, 3'h2, "power-on event flags");
    tick(1);
    main_below_por <= 1'b0;
    tick(2100);
    #1;
    check_bit(alert_n_oe, 1'h1, "power-on alert");
    // second reset mid-run with the power-loss nonvolatile bit cleared and the clock output disabled
    tick(1);
    nv_power_loss_irq_enable <= 1'b0;
    clock_output_disable <= 1'b1;
    resetn <= 1'b0;
    tick(8);
    resetn <= 1'b1;
    tick(2100);
    #1;
    check_bit(power_loss_irq_enable, 1'h0, "enable from zero copy");
    check_bit(alert_n_oe, 1'h0, "no power-on alert");
    check_bit(clock_output_pin, 1'h0, "clock output disabled");
    wrap_up();
  end
endmodule : tb_top
